/* hw/spi_osc_pkg.sv */
// Constants and types shared by the serial port and oscillator/reference block
package spi_osc_pkg;

  // ------------------------------------------------------------
  // Register addresses (5-bit register space)
  // ------------------------------------------------------------
  localparam logic [4:0] ADDR_OSC_REF = 5'h07;
  localparam logic [4:0] ADDR_SERIAL_CTRL = 5'h18;
  localparam logic [4:0] ADDR_REVISION = 5'h1F;
  localparam logic [4:0] ADDR_STEP = 5'h01;

  // ------------------------------------------------------------
  // Reset values and masks
  // ------------------------------------------------------------
  localparam logic [7:0] RESET_OSC_REF = 8'h00;
  localparam logic [7:0] RESET_SERIAL_CTRL = 8'h00;
  localparam logic [7:0] OSC_REF_USED_MASK = 8'h3F;
  localparam logic [7:0] SERIAL_USED_MASK = 8'hE7;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // Arbitrary neutral value, not tied to any real part
  localparam logic [7:0] REVISION_CODE_DEFAULT = 8'h5A;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int OSC_REF_CLK_SRC_BIT = 5;
  localparam int OSC_OUT_EN_BIT = 4;
  localparam int REF_POWER_BIT = 3;
  localparam int REF_BUFFER_BIT = 2;
  localparam int TWO_VOLT_BIT = 1;
  localparam int BANDGAP_BIT = 0;
  localparam int LSB_FIRST_HI_BIT = 7;
  localparam int LSB_FIRST_LO_BIT = 0;
  localparam int WIRE_MODE_HI_BIT = 6;
  localparam int WIRE_MODE_LO_BIT = 1;
  localparam int EARLY_REL_HI_BIT = 5;
  localparam int EARLY_REL_LO_BIT = 2;
  localparam int INSTR_CONVERT_BIT = 7;
  localparam int INSTR_READ_BIT = 6;
  localparam int INSTR_WORD_BIT = 5;

  // ------------------------------------------------------------
  // Serial framing and timing
  // ------------------------------------------------------------
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_STEP = 3'h1;
  localparam int CLK_FREQ_KHZ = 100000;
  localparam int OSC_FREQ_KHZ = 2500;
  localparam logic [4:0] OSC_HALF_CYCLES = 5'(CLK_FREQ_KHZ / (2 * OSC_FREQ_KHZ));
  localparam logic [4:0] OSC_CNT_STEP = 5'h01;
  localparam logic [2:0] DIV_LAST_BY1 = 3'h0;
  localparam logic [2:0] DIV_LAST_BY2 = 3'h1;
  localparam logic [2:0] DIV_LAST_BY4 = 3'h3;
  localparam logic [2:0] DIV_LAST_BY8 = 3'h7;
  localparam int WR_WORD_W = 13;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    REF_2V5 = 2'h0,
    REF_2V048 = 2'h1,
    REF_1V15 = 2'h2
  } ref_level_t;

  typedef enum logic [2:0] {
    PH_INSTR = 3'h1,
    PH_WRITE = 3'h2,
    PH_READ = 3'h4
  } phase_t;

endpackage : spi_osc_pkg

/* hw/two_entry_buffer.sv */
// Two-entry valid/ready buffer carrying register write words
`timescale 1ns/100ps
module two_entry_buffer #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL_COUNT = (PW + 1)'(DEPTH);
  localparam logic [PW-1:0] LAST_SLOT = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != FULL_COUNT);
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  // ------------------------------------------------------------
  // Pointers and occupancy
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= (wr_ptr == LAST_SLOT) ? '0 : PW'(wr_ptr + 1'b1);
      end
      if (pop)
      begin
        rd_ptr <= (rd_ptr == LAST_SLOT) ? '0 : PW'(rd_ptr + 1'b1);
      end
      if (push && !pop)
      begin
        count <= (PW + 1)'(count + 1'b1);
      end
      else if (pop && !push)
      begin
        count <= (PW + 1)'(count - 1'b1);
      end
    end
  end

endmodule : two_entry_buffer

/* hw/serial_port_and_osc_ref_config.sv */
// Serial slave port configuration with oscillator and reference enables
`timescale 1ns/100ps
module serial_port_and_osc_ref_config (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sclk_pin,
  input wire logic cs_n_pin,
  input wire logic din_in,
  output logic din_out,
  output logic din_oe_n,
  output logic dout_out,
  output logic dout_oe_n,
  input wire logic converter_clock_pin_in,
  output logic converter_clock_pin_out,
  output logic converter_clock_pin_oe_n,
  input wire logic oscillator_enable_pin,
  input wire logic clock_divider_bit_low,
  input wire logic clock_divider_bit_high,
  output logic oscillator_run,
  output logic oscillator_output_enable,
  output logic ref_clock_source_sel,
  output logic ref_clock_tick,
  output logic converter_clock_tick,
  output logic reference_power_up,
  output logic ref_buffer_power_enable,
  output logic two_volt_ref_select,
  output logic bandgap_ref_select,
  output spi_osc_pkg::ref_level_t ref_level,
  output logic ext_wr_valid,
  input wire logic ext_wr_ready,
  output logic [4:0] ext_wr_addr,
  output logic [7:0] ext_wr_data
);
  import spi_osc_pkg::*;

  parameter logic [7:0] REVISION_CODE = REVISION_CODE_DEFAULT;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  localparam int PIN_N = 5;
  localparam int P_SCLK = 0;
  localparam int P_CS = 1;
  localparam int P_DIN = 2;
  localparam int P_CONVERTER_CLOCK_PIN = 3;
  localparam int P_OSC = 4;
  // Chip select rests high, so its stages reset high and no false select follows reset
  localparam logic [PIN_N-1:0] PIN_IDLE = PIN_N'(1) << P_CS;

  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] pin_meta;
  logic [PIN_N-1:0] pin_sync;
  logic [PIN_N-1:0] pin_prev;

  assign pin_raw = {oscillator_enable_pin, converter_clock_pin_in, din_in, cs_n_pin, sclk_pin};

  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi++)
    begin : g_sync
      always_ff @(posedge clk or negedge nrst)
      begin
        if (!nrst)
        begin
          pin_meta[gi] <= PIN_IDLE[gi];
          pin_sync[gi] <= PIN_IDLE[gi];
          pin_prev[gi] <= PIN_IDLE[gi];
        end
        else
        begin
          pin_meta[gi] <= pin_raw[gi];
          pin_sync[gi] <= pin_meta[gi];
          pin_prev[gi] <= pin_sync[gi];
        end
      end
    end
  endgenerate

  logic cs_n_s;
  logic selected;
  logic sclk_rise;
  logic sclk_fall;
  logic din_s;
  logic converter_clock_pin_rise;
  logic osc_pin_s;

  // Edges compare the second and third stages, never the first
  assign cs_n_s = pin_sync[P_CS];
  assign selected = ~cs_n_s;
  assign sclk_rise = selected & pin_sync[P_SCLK] & ~pin_prev[P_SCLK];
  assign sclk_fall = selected & ~pin_sync[P_SCLK] & pin_prev[P_SCLK];
  assign din_s = pin_sync[P_DIN];
  assign converter_clock_pin_rise = pin_sync[P_CONVERTER_CLOCK_PIN] & ~pin_prev[P_CONVERTER_CLOCK_PIN];
  assign osc_pin_s = pin_sync[P_OSC];

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  logic [7:0] osc_ref_config;
  logic [7:0] serial_port_control;
  logic cfg_lsb_first;
  logic cfg_two_wire;
  logic cfg_early_release;

  // Either mirrored copy turns a function on
  assign cfg_lsb_first = serial_port_control[LSB_FIRST_HI_BIT]
                       | serial_port_control[LSB_FIRST_LO_BIT];
  assign cfg_two_wire = serial_port_control[WIRE_MODE_HI_BIT]
                      | serial_port_control[WIRE_MODE_LO_BIT];
  assign cfg_early_release = serial_port_control[EARLY_REL_HI_BIT]
                           | serial_port_control[EARLY_REL_LO_BIT];

  // ------------------------------------------------------------
  // Serial sequencing state
  // ------------------------------------------------------------
  phase_t phase;
  logic [2:0] bit_cnt;
  logic [4:0] cur_addr;
  logic second_byte;
  logic lsb_first_act;
  logic two_wire_act;
  logic [7:0] rx_sh;
  logic [7:0] rx_next;
  logic [7:0] rx_rev;
  logic [7:0] rx_byte;
  logic [7:0] tx_sh;
  logic out_bit;
  logic drive_on;
  logic byte_end;
  logic [4:0] rd_addr;
  logic [7:0] rd_byte;
  logic [7:0] rd_rev;
  logic [7:0] tx_load;

  assign rx_next = {rx_sh[6:0], din_s};
  assign byte_end = sclk_rise & (bit_cnt == BIT_LAST);

  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_rev
      assign rx_rev[gi] = rx_next[7-gi];
      assign rd_rev[gi] = rd_byte[7-gi];
    end
  endgenerate

  // Bits are always shifted in arrival order, then turned round if needed
  assign rx_byte = lsb_first_act ? rx_rev : rx_next;

  // ------------------------------------------------------------
  // Read data selection
  // ------------------------------------------------------------
  assign rd_addr = (phase == PH_INSTR) ? rx_byte[4:0] : 5'(cur_addr + ADDR_STEP);

  always_comb
  begin
    case (rd_addr)
      ADDR_OSC_REF: rd_byte = osc_ref_config;
      ADDR_SERIAL_CTRL: rd_byte = serial_port_control;
      ADDR_REVISION: rd_byte = REVISION_CODE;
      default: rd_byte = UNMAPPED_READ;
    endcase
  end

  // Transmit register always shifts its top bit out first
  assign tx_load = lsb_first_act ? rd_rev : rd_byte;

  // ------------------------------------------------------------
  // Bit order and wire mode snapshot
  // ------------------------------------------------------------
  // Taken only on the first edge of an instruction byte, so a change never
  // lands inside a byte; the symmetric control write decodes either way
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      lsb_first_act <= 1'b0;
      two_wire_act <= 1'b0;
    end
    else if (sclk_rise && phase == PH_INSTR && bit_cnt == BIT_FIRST)
    begin
      lsb_first_act <= cfg_lsb_first;
      two_wire_act <= cfg_two_wire;
    end
  end

  // ------------------------------------------------------------
  // Receive shifter and bit counter
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rx_sh <= 8'h00;
      bit_cnt <= BIT_FIRST;
    end
    else if (cs_n_s)
    begin
      bit_cnt <= BIT_FIRST;
    end
    else if (sclk_rise)
    begin
      rx_sh <= rx_next;
      bit_cnt <= 3'(bit_cnt + BIT_STEP);
    end
  end

  // ------------------------------------------------------------
  // Instruction / data phase sequencer
  // ------------------------------------------------------------
  logic pend_valid;
  logic [WR_WORD_W-1:0] pend_word;
  logic buf_in_ready;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      phase <= PH_INSTR;
      cur_addr <= 5'h00;
      second_byte <= 1'b0;
      tx_sh <= 8'h00;
    end
    else if (cs_n_s)
    begin
      phase <= PH_INSTR;
      second_byte <= 1'b0;
    end
    else if (byte_end)
    begin
      case (phase)
        PH_INSTR:
        begin
          // Convert commands belong to the converter core; stay ready for more
          if (!rx_byte[INSTR_CONVERT_BIT])
          begin
            cur_addr <= rx_byte[4:0];
            second_byte <= rx_byte[INSTR_WORD_BIT];
            if (rx_byte[INSTR_READ_BIT])
            begin
              phase <= PH_READ;
              tx_sh <= tx_load;
            end
            else
            begin
              phase <= PH_WRITE;
            end
          end
        end
        PH_WRITE:
        begin
          if (second_byte)
          begin
            second_byte <= 1'b0;
            cur_addr <= 5'(cur_addr + ADDR_STEP);
          end
          else
          begin
            phase <= PH_INSTR;
          end
        end
        PH_READ:
        begin
          if (second_byte)
          begin
            second_byte <= 1'b0;
            cur_addr <= 5'(cur_addr + ADDR_STEP);
            tx_sh <= tx_load;
          end
          else
          begin
            phase <= PH_INSTR;
          end
        end
        default:
        begin
          phase <= PH_INSTR;
        end
      endcase
    end
    else if (sclk_fall && phase == PH_READ)
    begin
      tx_sh <= {tx_sh[6:0], 1'b0};
    end
  end

  // ------------------------------------------------------------
  // Output bit and pin drive
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      out_bit <= 1'b0;
    end
    else if (sclk_fall && phase == PH_READ)
    begin
      out_bit <= tx_sh[7];
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      drive_on <= 1'b0;
    end
    else if (cs_n_s)
    begin
      drive_on <= 1'b0;
    end
    else if (byte_end && phase == PH_READ && !second_byte && cfg_early_release)
    begin
      drive_on <= 1'b0;
    end
    else if (sclk_fall)
    begin
      // Falling edge after the final bit is not a read phase any more
      drive_on <= (phase == PH_READ);
    end
  end

  // Data-out timing ignores wire mode; data-in only drives in two-wire mode
  assign dout_out = out_bit;
  assign dout_oe_n = ~drive_on;
  assign din_out = out_bit;
  assign din_oe_n = ~(drive_on & two_wire_act);

  // ------------------------------------------------------------
  // Write path through the two-entry buffer
  // ------------------------------------------------------------
  // The push waits in a holding slot while the buffer is full, so a slow
  // external consumer costs latency until a further write overwrites the held word
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pend_valid <= 1'b0;
      pend_word <= '0;
    end
    else if (byte_end && phase == PH_WRITE)
    begin
      pend_valid <= 1'b1;
      pend_word <= {cur_addr, rx_byte};
    end
    else if (buf_in_ready)
    begin
      pend_valid <= 1'b0;
    end
  end

  logic buf_out_valid;
  logic buf_out_ready;
  logic [WR_WORD_W-1:0] buf_out_data;
  logic wr_is_local;
  logic local_wr;

  two_entry_buffer #(
    .WIDTH(WR_WORD_W),
    .DEPTH(2)
  ) u_wr_buffer (
    .clk(clk),
    .nrst(nrst),
    .in_valid(pend_valid),
    .in_ready(buf_in_ready),
    .in_data(pend_word),
    .out_valid(buf_out_valid),
    .out_ready(buf_out_ready),
    .out_data(buf_out_data)
  );

  assign ext_wr_addr = buf_out_data[12:8];
  assign ext_wr_data = buf_out_data[7:0];
  assign wr_is_local = (ext_wr_addr == ADDR_OSC_REF)
                     | (ext_wr_addr == ADDR_SERIAL_CTRL)
                     | (ext_wr_addr == ADDR_REVISION);
  assign local_wr = buf_out_valid & wr_is_local;
  assign buf_out_ready = wr_is_local | ext_wr_ready;
  assign ext_wr_valid = buf_out_valid & ~wr_is_local;

  // ------------------------------------------------------------
  // Register updates
  // ------------------------------------------------------------
  // Reserved bits are dropped so they always read back as zero
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      osc_ref_config <= RESET_OSC_REF;
      serial_port_control <= RESET_SERIAL_CTRL;
    end
    else if (local_wr)
    begin
      if (ext_wr_addr == ADDR_OSC_REF)
      begin
        osc_ref_config <= ext_wr_data & OSC_REF_USED_MASK;
      end
      if (ext_wr_addr == ADDR_SERIAL_CTRL)
      begin
        serial_port_control <= ext_wr_data & SERIAL_USED_MASK;
      end
    end
  end

  assign ref_clock_source_sel = osc_ref_config[OSC_REF_CLK_SRC_BIT];
  assign oscillator_output_enable = osc_ref_config[OSC_OUT_EN_BIT];
  assign reference_power_up = osc_ref_config[REF_POWER_BIT];
  assign ref_buffer_power_enable = osc_ref_config[REF_BUFFER_BIT];
  assign two_volt_ref_select = osc_ref_config[TWO_VOLT_BIT];
  assign bandgap_ref_select = osc_ref_config[BANDGAP_BIT];

  always_comb
  begin
    if (bandgap_ref_select)
    begin
      ref_level = REF_1V15;
    end
    else if (two_volt_ref_select)
    begin
      ref_level = REF_2V048;
    end
    else
    begin
      ref_level = REF_2V5;
    end
  end

  // ------------------------------------------------------------
  // Internal oscillator
  // ------------------------------------------------------------
  // The source-plus-reference case is a subset of "either bit set"
  assign oscillator_run = osc_pin_s | ref_clock_source_sel
                        | oscillator_output_enable;

  logic [4:0] osc_cnt;
  logic osc_level;
  logic osc_rise;

  assign osc_rise = oscillator_run & ~osc_level & (osc_cnt == 5'(OSC_HALF_CYCLES - OSC_CNT_STEP));

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      osc_cnt <= 5'h00;
      osc_level <= 1'b0;
    end
    else if (!oscillator_run)
    begin
      osc_cnt <= 5'h00;
      osc_level <= 1'b0;
    end
    else if (osc_cnt == 5'(OSC_HALF_CYCLES - OSC_CNT_STEP))
    begin
      osc_cnt <= 5'h00;
      osc_level <= ~osc_level;
    end
    else
    begin
      osc_cnt <= 5'(osc_cnt + OSC_CNT_STEP);
    end
  end

  // Pin becomes an output only under the output-enable bit
  assign converter_clock_pin_out = osc_level;
  assign converter_clock_pin_oe_n = ~oscillator_output_enable;

  // ------------------------------------------------------------
  // Clock pin divider and reference clock
  // ------------------------------------------------------------
  logic [2:0] div_cnt;
  logic [2:0] div_last;

  always_comb
  begin
    case ({clock_divider_bit_high, clock_divider_bit_low})
      2'h0: div_last = DIV_LAST_BY1;
      2'h1: div_last = DIV_LAST_BY2;
      2'h2: div_last = DIV_LAST_BY4;
      default: div_last = DIV_LAST_BY8;
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      div_cnt <= 3'h0;
      converter_clock_tick <= 1'b0;
    end
    else if (converter_clock_pin_rise)
    begin
      converter_clock_tick <= (div_cnt >= div_last);
      div_cnt <= (div_cnt >= div_last) ? 3'h0 : 3'(div_cnt + BIT_STEP);
    end
    else
    begin
      converter_clock_tick <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ref_clock_tick <= 1'b0;
    end
    else
    begin
      ref_clock_tick <= ref_clock_source_sel ? osc_rise
                                             : (converter_clock_pin_rise && div_cnt >= div_last);
    end
  end

endmodule : serial_port_and_osc_ref_config

/* dv/serial_port_and_osc_ref_config_checker.sv */
// Port-level checks for the serial port and osc/ref block
`timescale 1ns/100ps
module serial_port_and_osc_ref_config_checker
  import spi_osc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic cs_n_pin,
  input wire logic din_out,
  input wire logic din_oe_n,
  input wire logic dout_out,
  input wire logic dout_oe_n,
  input wire logic converter_clock_pin_oe_n,
  input wire logic oscillator_run,
  input wire logic oscillator_output_enable,
  input wire logic ref_clock_source_sel,
  input wire logic two_volt_ref_select,
  input wire logic bandgap_ref_select,
  input wire spi_osc_pkg::ref_level_t ref_level,
  input wire logic ext_wr_valid,
  input wire logic ext_wr_ready,
  input wire logic [4:0] ext_wr_addr,
  input wire logic [7:0] ext_wr_data
);
  // ------
  // Checks
  // ------
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Two cycles of margin so a registered enable does not trip the check
  a_osc_bits_run: assert property (
    (ref_clock_source_sel || oscillator_output_enable) [*2] |-> oscillator_run)
    else $error("oscillator idle with a control bit set");
  a_pin_drive: assert property (
    oscillator_output_enable [*2] |-> !converter_clock_pin_oe_n)
    else $error("clock pin not driven");
  a_pin_input: assert property (
    !oscillator_output_enable [*2] |-> converter_clock_pin_oe_n)
    else $error("clock pin driven without enable");
  a_bandgap_level: assert property (
    bandgap_ref_select |-> ref_level == REF_1V15)
    else $error("bandgap level wrong");
  a_two_volt_level: assert property (
    !bandgap_ref_select && two_volt_ref_select |-> ref_level == REF_2V048)
    else $error("two-volt level wrong");
  a_default_level: assert property (
    !bandgap_ref_select && !two_volt_ref_select |-> ref_level == REF_2V5)
    else $error("default level wrong");
  a_two_wire_copy: assert property (
    !din_oe_n |-> !dout_oe_n && din_out == dout_out)
    else $error("data-in pin drive mismatch");
  a_deselect_float: assert property (
    $rose(cs_n_pin) |-> ##[1:5] (dout_oe_n && din_oe_n))
    else $error("pins not floated after deselect");
  a_ext_hold: assert property (
    ext_wr_valid && !ext_wr_ready |=> ext_wr_valid && $stable(ext_wr_addr)
      && $stable(ext_wr_data))
    else $error("stalled write word changed");
  c_two_wire: cover property (!din_oe_n);
  c_ext_xfer: cover property (ext_wr_valid && ext_wr_ready);
  c_bandgap: cover property (bandgap_ref_select && two_volt_ref_select);
endmodule : serial_port_and_osc_ref_config_checker

/* dv/spi_host_model.sv */
// Host serial master model for the block's serial pins
`timescale 1ns/100ps
module spi_host_model (
  input wire logic clk,
  output logic sclk_pin,
  output logic cs_n_pin,
  output logic host_din,
  input wire logic dout_out,
  input wire logic dout_oe_n
);
  // ------
  // Bus cycles
  // ------
  // Eight clocks per level keeps every edge well past the pin synchronisers
  localparam int HALF = 8;
  logic lsb_first = 1'b0;
  logic end_oe_n = 1'b1;
  initial
  begin
    sclk_pin = 1'b0;
    cs_n_pin = 1'b1;
    host_din = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    int b;
    for (int i = 0; i < 8; i++)
    begin
      b = lsb_first ? i : 7 - i;
      host_din = tx[b];
      tick(HALF);
      sclk_pin = 1'b1;
      rx[b] = dout_out;
      tick(HALF);
      end_oe_n = dout_oe_n;
      sclk_pin = 1'b0;
    end
  endtask : xfer
  task automatic access(input logic [7:0] ins, input logic [7:0] wd, output logic [7:0] rd);
    logic [7:0] dummy;
    cs_n_pin = 1'b0;
    tick(4);
    xfer(ins, dummy);
    xfer(wd, rd);
    tick(4);
    cs_n_pin = 1'b1;
    tick(12);
  endtask : access
endmodule : spi_host_model

/* dv/serial_port_and_osc_ref_config_tb.sv */
// Self-checking bench for the serial port and osc/ref block
`timescale 1ns/100ps
module serial_port_and_osc_ref_config_tb;
  import spi_osc_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic sclk_pin, cs_n_pin, host_din, din_out, din_oe_n, dout_out, dout_oe_n;
  logic converter_clock_pin_in = 1'b0;
  logic clock_divider_bit_low = 1'b0;
  logic clock_divider_bit_high = 1'b0;
  logic oscillator_enable_pin = 1'b0;
  logic ext_wr_ready = 1'b0;
  logic converter_clock_pin_oe_n, oscillator_run, oscillator_output_enable;
  logic ref_clock_source_sel, reference_power_up, ref_buffer_power_enable;
  logic two_volt_ref_select, bandgap_ref_select, ext_wr_valid;
  logic [4:0] ext_wr_addr;
  logic [7:0] ext_wr_data, got, v, c;
  ref_level_t ref_level;
  logic seen2w = 1'b0;
  logic ref_clock_tick, converter_clock_tick, converter_clock_pin_out;
  logic osc_seen = 1'b0;
  int n_cct = 0;
  int n_rct = 0;
  int n_mismatch = 0;
  int checks = 0;
  logic [7:0] ov [8] = '{8'h10, 8'h28, 8'h23, 8'h01, 8'h02, 8'h04, 8'h08, 8'h00};
  logic [7:0] sv [5] = '{8'h01, 8'h80, 8'h42, 8'h24, 8'h00};
  // Host keeps driving the shared data wire unless the block takes it
  wire din_in = din_oe_n ? host_din : din_out;
  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    if (!din_oe_n) seen2w <= 1'b1;
    if (converter_clock_pin_out) osc_seen <= 1'b1;
    n_cct <= n_cct + int'(converter_clock_tick);
    n_rct <= n_rct + int'(ref_clock_tick);
  end
  serial_port_and_osc_ref_config serial_port_and_osc_ref_config_i (.*);
  spi_host_model spi_host_model_i (.*);
  // ------
  // Tasks
  // ------
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    spi_host_model_i.access({3'b000, a}, d, got);
  endtask : wr
  task automatic rd(input logic [4:0] a);
    spi_host_model_i.access({3'b010, a}, 8'hA5, got);
  endtask : rd
  // Eight clock-pin rising edges per divider setting; divider count ends at zero each time
  task automatic converter_clock_pin_run(input logic [1:0] sel, input int n);
    int c0;
    int r0;
    {clock_divider_bit_high, clock_divider_bit_low} = sel;
    c0 = n_cct;
    r0 = n_rct;
    repeat (16)
    begin
      converter_clock_pin_in = ~converter_clock_pin_in;
      spi_host_model_i.tick(4);
    end
    spi_host_model_i.tick(4);
    chk(8'(n_cct - c0), 8'(n));
    chk(8'(n_rct - r0), 8'(n));
  endtask : converter_clock_pin_run
  task automatic print_verdict;
    if (n_mismatch == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  // ------
  // Sequence
  // ------
  initial
  begin
    #200000;
    n_mismatch++;
    print_verdict;
  end
  initial
  begin
    repeat (6) @(posedge clk);
    #1;
    nrst = 1'b1;
    spi_host_model_i.tick(6);
    chk({4'h0, oscillator_run, reference_power_up, dout_oe_n, din_oe_n}, 8'h03);
    converter_clock_pin_run(2'h0, 8);
    converter_clock_pin_run(2'h1, 4);
    converter_clock_pin_run(2'h2, 2);
    converter_clock_pin_run(2'h3, 1);
    rd(ADDR_OSC_REF);
    chk(got, RESET_OSC_REF);
    rd(ADDR_SERIAL_CTRL);
    chk(got, RESET_SERIAL_CTRL);
    foreach (ov[i])
    begin
      wr(ADDR_OSC_REF, ov[i]);
      v = ov[i] & OSC_REF_USED_MASK;
      osc_seen = 1'b0;
      chk({2'h0, ref_clock_source_sel, oscillator_output_enable, reference_power_up,
        ref_buffer_power_enable, two_volt_ref_select, bandgap_ref_select}, v);
      chk({6'h0, oscillator_run, converter_clock_pin_oe_n}, {6'h0, v[5] | v[4], !v[4]});
      chk({6'h0, ref_level}, v[0] ? 8'(REF_1V15) : v[1] ? 8'(REF_2V048) : 8'(REF_2V5));
      rd(ADDR_OSC_REF);
      chk(got, v);
      chk({7'h0, osc_seen}, {7'h0, v[5] | v[4]});
    end
    oscillator_enable_pin = 1'b1;
    spi_host_model_i.tick(5);
    chk({7'h0, oscillator_run}, 8'h01);
    oscillator_enable_pin = 1'b0;
    spi_host_model_i.tick(5);
    chk({7'h0, oscillator_run}, 8'h00);
    wr(ADDR_REVISION, 8'hFF);
    rd(ADDR_REVISION);
    chk(got, REVISION_CODE_DEFAULT);
    rd(5'h09);
    chk(got, UNMAPPED_READ);
    // Non-palindromic value exposes a wrong bit order on readback
    wr(ADDR_OSC_REF, 8'h0C);
    foreach (sv[i])
    begin
      c = sv[i];
      wr(ADDR_SERIAL_CTRL, c);
      spi_host_model_i.lsb_first = c[7] | c[0];
      seen2w = 1'b0;
      rd(ADDR_OSC_REF);
      chk(got, 8'h0C);
      chk({6'h0, seen2w, spi_host_model_i.end_oe_n}, {6'h0, c[6] | c[1], c[5] | c[2]});
      rd(ADDR_SERIAL_CTRL);
      chk(got, c & SERIAL_USED_MASK);
    end
    wr(5'h03, 8'h11);
    wr(5'h02, 8'h22);
    chk({2'h0, ext_wr_valid, ext_wr_addr}, 8'h23);
    chk(ext_wr_data, 8'h11);
    ext_wr_ready = 1'b1;
    spi_host_model_i.tick(1);
    ext_wr_ready = 1'b0;
    spi_host_model_i.tick(2);
    chk({2'h0, ext_wr_valid, ext_wr_addr}, 8'h22);
    chk(ext_wr_data, 8'h22);
    ext_wr_ready = 1'b1;
    spi_host_model_i.tick(3);
    chk({7'h0, ext_wr_valid}, 8'h00);
    print_verdict;
  end
endmodule : serial_port_and_osc_ref_config_tb
bind serial_port_and_osc_ref_config serial_port_and_osc_ref_config_checker
  serial_port_and_osc_ref_config_checker_i (.*);
